// ### design/flash_pkg.sv
package flash_pkg;
    localparam logic [7:0]  OPC_WR_ENABLE  = 8'h06;
    localparam logic [7:0]  OPC_QUAD_PROG  = 8'h32;
    localparam logic [7:0]  OPC_SECT_ERASE = 8'h20;
    localparam logic [7:0]  OPC_B32_ERASE  = 8'h52;
    localparam logic [7:0]  OPC_B64_ERASE  = 8'hd8;
    localparam logic [7:0]  OPC_CHIP_A     = 8'h60;
    localparam logic [7:0]  OPC_CHIP_B     = 8'hc7;
    localparam logic [7:0]  OPC_DEEP_SLEEP = 8'hb9;
    localparam logic [7:0]  OPC_WAKE_ID    = 8'hab;
    // sclk rising-edge counts that mark frame boundaries, and the count's saturation value
    localparam logic [11:0] EDGE_OPC_END   = 12'h008;
    localparam logic [11:0] EDGE_QADDR_END = 12'h00e;
    localparam logic [11:0] EDGE_ADDR_END  = 12'h020;
    localparam logic [11:0] EDGE_SAT       = 12'hfff;
    localparam int          PAGE_BYTES     = 256;
    localparam logic [23:0] SECT_MASK      = 24'hfff000;
    localparam logic [23:0] B32_MASK       = 24'hff8000;
    localparam logic [23:0] B64_MASK       = 24'hff0000;
    localparam logic [7:0]  NUM_BLOCKS     = 8'h80;
    localparam logic [2:0]  BP_NONE        = 3'h0;
    localparam logic [2:0]  BP_ALL         = 3'h7;
    localparam int          CLK_KHZ        = 10000;
    localparam int          T_PP_US        = 600;
    localparam int          T_SE_MS        = 50;
    localparam int          T_B32_MS       = 150;
    localparam int          T_B64_MS       = 200;
    localparam int          T_CE_MS        = 20000;
    localparam int          T_DP_US        = 3;
    localparam int          T_RES1_US      = 3;
    localparam int          T_RES2_US      = 2;
    localparam int          PP_CYC   = T_PP_US * CLK_KHZ / 1000;
    localparam int          SE_CYC   = T_SE_MS * CLK_KHZ;
    localparam int          B32_CYC  = T_B32_MS * CLK_KHZ;
    localparam int          B64_CYC  = T_B64_MS * CLK_KHZ;
    localparam int          CE_CYC   = T_CE_MS * CLK_KHZ;
    localparam int          DP_CYC   = T_DP_US * CLK_KHZ / 1000;
    localparam int          RES1_CYC = T_RES1_US * CLK_KHZ / 1000;
    localparam int          RES2_CYC = T_RES2_US * CLK_KHZ / 1000;
    // arbitrary value, not tied to any part
    localparam logic [7:0]  DEV_ID_DEFAULT = 8'h5a;

    typedef enum logic [1:0] {
        PH_OPC = 2'b00, PH_ADDR = 2'b01, PH_DATA = 2'b11, PH_IDOUT = 2'b10
    } phase_t;
    typedef enum logic [1:0] {
        PW_STBY = 2'b00, PW_ENTER = 2'b01, PW_SLEEP = 2'b11, PW_WAKE = 2'b10
    } power_t;
    typedef enum logic [1:0] {
        ER_SECT = 2'b00, ER_B32 = 2'b01, ER_B64 = 2'b10, ER_CHIP = 2'b11
    } erase_kind_t;
    typedef struct packed {
        logic [4:0] bits;
        logic       complement;
    } protect_cfg_t;
    typedef struct packed {
        logic        en;
        logic [23:0] addr;
        logic [7:0]  data;
    } mem_wr_t;
    typedef struct packed {
        logic        en;
        erase_kind_t kind;
        logic [23:0] addr;
    } erase_req_t;
endpackage

// ### design/flash_seq.sv
`timescale 1ns/10ps
// Behaviour
// - quad program: 32H, address, data on four lines
// - over 256 bytes: last 256 kept, same page
// - under 256 bytes: other page bytes untouched
// - program runs only if frame ends on byte
// - busy flag high through whole self-timed cycle
// - write latch cleared during every self-timed cycle
// - program to protected page not executed
// - sector erase 20H, any address in sector
// - 32KB erase 52H, any address in block
// - 64KB erase D8H, any address in block
// - erase runs only if frame ends after address
// - erase of protected region refused
// - chip erase 60H/C7H, exactly eight bits
// - chip erase only with nothing protected
// - B9H exact; sleep after entry delay
// - asleep: only ABH is obeyed
// - sleep command rejected while busy
// - reset always starts in standby
// - plain wake: nothing accepted during wake delay
// - ABH, three dummy bytes, ID repeats MSB first
// - wake with ID: second wake delay applies
// - ABH ignored while busy
module flash_seq #(
    parameter int         PP_CYCLES   = flash_pkg::PP_CYC,   // program
    parameter int         SE_CYCLES   = flash_pkg::SE_CYC,   // sector
    parameter int         B32_CYCLES  = flash_pkg::B32_CYC,  // 32KB
    parameter int         B64_CYCLES  = flash_pkg::B64_CYC,  // 64KB
    parameter int         CE_CYCLES   = flash_pkg::CE_CYC,   // chip
    parameter int         DP_CYCLES   = flash_pkg::DP_CYC,   // sleep entry
    parameter int         RES1_CYCLES = flash_pkg::RES1_CYC, // plain wake
    parameter int         RES2_CYCLES = flash_pkg::RES2_CYC, // wake with id
    parameter logic [7:0] DEVICE_ID   = flash_pkg::DEV_ID_DEFAULT
) (
    input  wire logic                    clk,          // 10 MHz
    input  wire logic                    rst_n,        // sync, low
    input  wire logic                    cs_n,         // chip select pin
    input  wire logic                    sclk,         // serial clock pin
    input  wire logic [3:0]              quad_io_in,   // io lines in
    output logic [3:0]                   quad_io_out,  // io lines out
    output logic [3:0]                   quad_io_oe,   // high = driving
    input  wire flash_pkg::protect_cfg_t protect_cfg,  // protect bits
    output logic                         write_latch_flag,    // latch
    output logic                         op_in_progress_flag, // busy
    output logic                         deep_sleep_flag,     // asleep
    output flash_pkg::mem_wr_t           mem_wr,       // byte write
    output flash_pkg::erase_req_t        erase_req     // erase pulse
);
    // pins: cs_n, sclk, io[3:0]
    logic [5:0]          pin_s1_ff;
    logic [5:0]          pin_s2_ff;
    logic [5:0]          pin_s3_ff;
    logic [11:0]         edge_cnt_ff;
    logic [7:0]          opc_ff;
    logic [23:0]         addr_ff;
    logic [7:0]          col_ff;
    logic [3:0]          hi_nib_ff;
    logic                nib_ff;
    logic [7:0]          page_buf [flash_pkg::PAGE_BYTES];
    logic [255:0]        mask_ff;
    logic [15:0]         pg_ff;
    logic                drain_on_ff;
    logic [7:0]          drain_idx_ff;
    logic [31:0]         tmr_ff;
    logic [31:0]         pwr_cnt_ff;
    logic                wel_ff;
    logic [2:0]          id_idx_ff;
    flash_pkg::phase_t   ph_ff;
    flash_pkg::phase_t   nxt_ph;
    flash_pkg::power_t   pwr_ff;

    wire       cs_hi_w   = pin_s2_ff[5];
    wire       rise_w    = pin_s2_ff[4] & ~pin_s3_ff[4] & ~cs_hi_w;
    wire       fall_w    = ~pin_s2_ff[4] & pin_s3_ff[4] & ~cs_hi_w;
    wire       cs_end_w  = cs_hi_w & ~pin_s3_ff[5];
    wire       cs_beg_w  = ~cs_hi_w & pin_s3_ff[5];
    wire [3:0] io_w      = pin_s2_ff[3:0];
    wire       busy_w    = tmr_ff != 32'h0;

    // frame decode
    wire [11:0] nxt_edge_w = (edge_cnt_ff == flash_pkg::EDGE_SAT) ?
                             edge_cnt_ff : edge_cnt_ff + 12'h001;
    wire quad_w   = opc_ff == flash_pkg::OPC_QUAD_PROG;
    wire [23:0] nxt_addr_w = quad_w ? {addr_ff[19:0], io_w}
                                    : {addr_ff[22:0], io_w[0]};
    wire exact8_w  = edge_cnt_ff == flash_pkg::EDGE_OPC_END;
    wire exact32_w = edge_cnt_ff == flash_pkg::EDGE_ADDR_END;
    wire is_sect_w = opc_ff == flash_pkg::OPC_SECT_ERASE;
    wire is_b32_w  = opc_ff == flash_pkg::OPC_B32_ERASE;
    wire is_b64_w  = opc_ff == flash_pkg::OPC_B64_ERASE;
    wire is_chip_w = opc_ff == flash_pkg::OPC_CHIP_A ||
                     opc_ff == flash_pkg::OPC_CHIP_B;
    wire is_wake_w = opc_ff == flash_pkg::OPC_WAKE_ID;

    // top blocks protected; complement flips the region
    function automatic logic blk_prot(input logic [6:0] blk,
                                      input flash_pkg::protect_cfg_t p);
        logic [7:0] top;
        logic       hit;
        top = 8'h01 << (p.bits[2:0] - 3'h1);
        if (p.bits[2:0] == flash_pkg::BP_ALL)
            hit = 1'b1;
        else if (p.bits[2:0] == flash_pkg::BP_NONE)
            hit = 1'b0;
        else
            hit = {1'b0, blk} >= (flash_pkg::NUM_BLOCKS - top);
        return hit ^ p.complement;
    endfunction

    wire chip_ok_w =
        (protect_cfg.bits[2:0] == flash_pkg::BP_NONE &&
         !protect_cfg.complement) ||
        (protect_cfg.bits[2:0] == flash_pkg::BP_ALL &&
         protect_cfg.complement);
    wire addr_prot_w = blk_prot(addr_ff[22:16], protect_cfg);

    // commands other than ABH are obeyed only awake, idle and outside wake delay
    wire idle_w  = pwr_ff == flash_pkg::PW_STBY && !busy_w;
    wire write_enable_cmd_go = cs_end_w & idle_w & exact8_w &
                   (opc_ff == flash_pkg::OPC_WR_ENABLE);
    // byte boundary: the partial nibble flag must be clear
    wire pp_go   = cs_end_w & idle_w & wel_ff & quad_w &
                   (ph_ff == flash_pkg::PH_DATA) & !nib_ff &
                   (|mask_ff) & !addr_prot_w;
    wire er_go   = cs_end_w & idle_w & wel_ff & exact32_w &
                   (is_sect_w | is_b32_w | is_b64_w) &
                   !addr_prot_w;
    wire ce_go   = cs_end_w & idle_w & wel_ff & exact8_w &
                   is_chip_w & chip_ok_w;
    wire dp_go   = cs_end_w & idle_w & exact8_w &
                   (opc_ff == flash_pkg::OPC_DEEP_SLEEP);
    wire wake_id_w = edge_cnt_ff >= flash_pkg::EDGE_ADDR_END;
    wire wake_go = cs_end_w & (pwr_ff == flash_pkg::PW_SLEEP) &
                   !busy_w & is_wake_w &
                   (exact8_w | wake_id_w);
    wire start_w = pp_go | er_go | ce_go;
    wire [31:0] er_cyc_w = is_sect_w ? 32'(SE_CYCLES) :
                           is_b32_w  ? 32'(B32_CYCLES) :
                                       32'(B64_CYCLES);
    wire [23:0] er_addr_w =
        is_sect_w ? (addr_ff & flash_pkg::SECT_MASK) :
        is_b32_w  ? (addr_ff & flash_pkg::B32_MASK) :
                    (addr_ff & flash_pkg::B64_MASK);
    wire flash_pkg::erase_kind_t er_kind_w =
        is_sect_w ? flash_pkg::ER_SECT :
        is_b32_w  ? flash_pkg::ER_B32 : flash_pkg::ER_B64;
    // capture strobes; page buffer frozen while a cycle drains it
    wire byte_w  = rise_w & (ph_ff == flash_pkg::PH_DATA) & quad_w &
                   nib_ff & !busy_w;
    wire id_on_w = fall_w & (ph_ff == flash_pkg::PH_IDOUT) & !busy_w;

    always_comb begin
        nxt_ph = ph_ff;
        if (cs_hi_w)
            nxt_ph = flash_pkg::PH_OPC;
        else if (rise_w) begin
            if (nxt_edge_w == flash_pkg::EDGE_OPC_END)
                nxt_ph = flash_pkg::PH_ADDR;
            else if (quad_w && nxt_edge_w == flash_pkg::EDGE_QADDR_END)
                nxt_ph = flash_pkg::PH_DATA;
            else if (!quad_w && nxt_edge_w == flash_pkg::EDGE_ADDR_END)
                nxt_ph = is_wake_w ? flash_pkg::PH_IDOUT
                                   : flash_pkg::PH_DATA;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pin_s1_ff <= 6'h3f;
            pin_s2_ff <= 6'h3f;
            pin_s3_ff <= 6'h3f;
        end else begin
            pin_s1_ff <= {cs_n, sclk, quad_io_in};
            pin_s2_ff <= pin_s1_ff;
            pin_s3_ff <= pin_s2_ff;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ph_ff       <= flash_pkg::PH_OPC;
            edge_cnt_ff <= 12'h000;
            opc_ff      <= 8'h00;
            addr_ff     <= 24'h000000;
        end else begin
            ph_ff <= nxt_ph;
            if (cs_hi_w)
                edge_cnt_ff <= 12'h000;
            else if (rise_w)
                edge_cnt_ff <= nxt_edge_w;
            if (rise_w && ph_ff == flash_pkg::PH_OPC)
                opc_ff <= {opc_ff[6:0], io_w[0]};
            if (rise_w && ph_ff == flash_pkg::PH_ADDR)
                addr_ff <= nxt_addr_w;
        end
    end

    // page column wraps inside the page, so later bytes overwrite
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            col_ff    <= 8'h00;
            nib_ff    <= 1'b0;
            hi_nib_ff <= 4'h0;
        end else begin
            if (cs_beg_w)
                nib_ff <= 1'b0;
            if (rise_w && ph_ff == flash_pkg::PH_ADDR &&
                nxt_ph == flash_pkg::PH_DATA)
                col_ff <= nxt_addr_w[7:0];
            else if (byte_w)
                col_ff <= col_ff + 8'h01;
            if (rise_w && ph_ff == flash_pkg::PH_DATA && quad_w) begin
                nib_ff    <= ~nib_ff;
                hi_nib_ff <= io_w;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (byte_w)
            page_buf[col_ff] <= {hi_nib_ff, io_w};
    end

    // only written bytes are flagged for programming
    always_ff @(posedge clk) begin
        if (!rst_n)
            mask_ff <= '0;
        else if (cs_beg_w && !busy_w)
            mask_ff <= '0;
        else if (byte_w)
            mask_ff[col_ff] <= 1'b1;
    end

    // self-timed cycle and program drain
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tmr_ff       <= 32'h0;
            drain_on_ff  <= 1'b0;
            drain_idx_ff <= 8'h00;
            pg_ff        <= 16'h0000;
        end else begin
            if (pp_go)
                tmr_ff <= 32'(PP_CYCLES);
            else if (er_go)
                tmr_ff <= er_cyc_w;
            else if (ce_go)
                tmr_ff <= 32'(CE_CYCLES);
            else if (busy_w)
                tmr_ff <= tmr_ff - 32'h1;
            if (pp_go) begin
                drain_on_ff  <= 1'b1;
                drain_idx_ff <= 8'h00;
                pg_ff        <= addr_ff[23:8];
            end else if (drain_on_ff) begin
                drain_idx_ff <= drain_idx_ff + 8'h01;
                drain_on_ff  <= drain_idx_ff != 8'hff;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mem_wr    <= '0;
            erase_req <= '0;
        end else begin
            mem_wr.en   <= drain_on_ff & mask_ff[drain_idx_ff];
            mem_wr.addr <= {pg_ff, drain_idx_ff};
            mem_wr.data <= page_buf[drain_idx_ff];
            erase_req.en <= er_go | ce_go;
            if (er_go) begin
                erase_req.kind <= er_kind_w;
                erase_req.addr <= er_addr_w;
            end else if (ce_go) begin
                erase_req.kind <= flash_pkg::ER_CHIP;
                erase_req.addr <= 24'h000000;
            end
        end
    end

    // latch cleared as each cycle starts
    always_ff @(posedge clk) begin
        if (!rst_n)
            wel_ff <= 1'b0;
        else if (start_w)
            wel_ff <= 1'b0;
        else if (write_enable_cmd_go)
            wel_ff <= 1'b1;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pwr_ff     <= flash_pkg::PW_STBY;
            pwr_cnt_ff <= 32'h0;
        end else begin
            case (pwr_ff)
                flash_pkg::PW_STBY: begin
                    if (dp_go) begin
                        pwr_ff     <= flash_pkg::PW_ENTER;
                        pwr_cnt_ff <= 32'(DP_CYCLES);
                    end
                end
                flash_pkg::PW_ENTER: begin
                    pwr_cnt_ff <= pwr_cnt_ff - 32'h1;
                    if (pwr_cnt_ff <= 32'h1)
                        pwr_ff <= flash_pkg::PW_SLEEP;
                end
                flash_pkg::PW_SLEEP: begin
                    if (wake_go) begin
                        pwr_ff     <= flash_pkg::PW_WAKE;
                        pwr_cnt_ff <= wake_id_w ? 32'(RES2_CYCLES)
                                                : 32'(RES1_CYCLES);
                    end
                end
                flash_pkg::PW_WAKE: begin
                    pwr_cnt_ff <= pwr_cnt_ff - 32'h1;
                    if (pwr_cnt_ff <= 32'h1)
                        pwr_ff <= flash_pkg::PW_STBY;
                end
                default: pwr_ff <= flash_pkg::PW_STBY;
            endcase
        end
    end

    // id shifts on sclk falls, repeating until deselect
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            id_idx_ff   <= 3'h0;
            quad_io_out <= 4'h0;
            quad_io_oe  <= 4'h0;
        end else if (cs_hi_w) begin
            id_idx_ff  <= 3'h0;
            quad_io_oe <= 4'h0;
        end else if (id_on_w) begin
            id_idx_ff      <= id_idx_ff + 3'h1;
            quad_io_out[1] <= DEVICE_ID[3'h7 - id_idx_ff];
            quad_io_oe[1]  <= 1'b1;
        end
    end

    assign write_latch_flag    = wel_ff;
    assign op_in_progress_flag = busy_w;
    assign deep_sleep_flag     = pwr_ff == flash_pkg::PW_SLEEP;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_pp_busy_start: assert property (pp_go |=> op_in_progress_flag)
        else $error("program did not raise busy");
    a_busy_hold_min: assert property ($rose(op_in_progress_flag) |->
        op_in_progress_flag [*8])
        else $error("busy dropped early");
    a_latch_clear: assert property ($rose(op_in_progress_flag) |->
        !write_latch_flag)
        else $error("write latch still set in cycle");
    a_pp_unprot: assert property (pp_go |-> !blk_prot(addr_ff[22:16],
        protect_cfg))
        else $error("protected page programmed");
    a_sect_align: assert property (erase_req.en &&
        erase_req.kind == flash_pkg::ER_SECT |->
        erase_req.addr[11:0] == 12'h000)
        else $error("sector address not aligned");
    a_b32_align: assert property (erase_req.en &&
        erase_req.kind == flash_pkg::ER_B32 |->
        erase_req.addr[14:0] == 15'h0000)
        else $error("32KB address not aligned");
    a_b64_align: assert property (erase_req.en &&
        erase_req.kind == flash_pkg::ER_B64 |->
        erase_req.addr[15:0] == 16'h0000)
        else $error("64KB address not aligned");
    a_erase_unprot: assert property (erase_req.en &&
        erase_req.kind != flash_pkg::ER_CHIP |->
        !blk_prot(erase_req.addr[22:16], $past(protect_cfg)))
        else $error("protected region erased");
    a_chip_guard: assert property (ce_go |-> ##1 erase_req.en &&
        erase_req.kind == flash_pkg::ER_CHIP && $past(chip_ok_w))
        else $error("chip erase with protection");
    // latch may stand from before sleep; it must not be set while asleep
    a_sleep_quiet: assert property (deep_sleep_flag && !write_latch_flag
        |=> !start_w && !write_latch_flag)
        else $error("command obeyed while asleep");
    a_dp_not_busy: assert property ($rose(pwr_ff == flash_pkg::PW_ENTER)
        |-> $past(!op_in_progress_flag))
        else $error("sleep entered while busy");
    a_wake_quiet: assert property (pwr_ff == flash_pkg::PW_WAKE |->
        !start_w && !dp_go)
        else $error("command taken during wake delay");
    a_id_not_busy: assert property (quad_io_oe[1] |->
        !op_in_progress_flag)
        else $error("id driven while busy");

    c_prog_run: cover property (pp_go ##[1:300] mem_wr.en);
    c_chip_erase: cover property (ce_go);
    c_wake_id: cover property (wake_go && wake_id_w);
    c_dp_enter: cover property (dp_go ##[1:100] deep_sleep_flag);
endmodule

// ### verif/spi_host.sv
`timescale 1ns/10ps
module spi_host (
    input  wire logic       clk,         // device clock
    input  wire logic [3:0] quad_io_out, // lines from device
    output logic            cs_n,        // chip select
    output logic            sclk,        // idles high between frames
    output logic [3:0]      quad_io_in   // lines to device
);
    logic [7:0] id_rd; // last eight bits seen on io1
    initial begin
        cs_n = 1'b1;
        sclk = 1'b1;
        quad_io_in = 4'h0;
        id_rd = 8'h00;
    end
    // io changes on the low phase; id sampled late in the high phase
    task automatic shift(input logic [63:0] v, input int n, input bit q);
        for (int i = n - 1; i >= 0; i--) begin
            @(posedge clk);
            sclk <= 1'b0;
            quad_io_in <= q ? v[i*4 +: 4] : {quad_io_in[3:1], v[i]};
            repeat (4) @(posedge clk);
            sclk <= 1'b1;
            repeat (3) @(posedge clk);
            id_rd <= {id_rd[6:0], quad_io_out[1]};
        end
    endtask
    // cs rises right after the last bit; gap keeps it high after
    task automatic send(input logic [7:0] opc, input logic [63:0] v,
                        input int n, input bit q);
        @(posedge clk);
        cs_n <= 1'b0;
        repeat (4) @(posedge clk);
        shift({56'h0, opc}, 8, 1'b0);
        if (n > 0) shift(v, n, q);
        @(posedge clk);
        cs_n <= 1'b1;
        quad_io_in <= ~quad_io_in;
        repeat (8) @(posedge clk);
    endtask
endmodule

// ### verif/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    localparam int PP = 300, SE = 40, B32 = 50, B64 = 60, CE = 150;
    localparam int DLY = 20;
    typedef struct packed {
        logic [7:0]  opc;
        logic [23:0] addr;
        logic [5:0]  nb;
        logic        we;
        logic [5:0]  prot;
        logic        en;
        logic [1:0]  kind;
        logic [23:0] ea;
    } row_t;
    logic                    clk = 1'b0;
    logic                    rst_n = 1'b0;
    logic                    cs_n, sclk;
    logic [3:0]              quad_io_in, quad_io_out, quad_io_oe;
    flash_pkg::protect_cfg_t protect_cfg = '0;
    logic                    write_latch_flag, op_in_progress_flag;
    logic                    deep_sleep_flag;
    flash_pkg::mem_wr_t      mem_wr, mw_last;
    flash_pkg::erase_req_t   erase_req, er_last;
    int                      n_errors = 0, n_tests = 0;
    int                      n_er = 0, n_mw = 0, k;
    int                      busy_cnt = 0, busy_len = 0;
    row_t                    rows [11];
    flash_seq #(.PP_CYCLES(PP), .SE_CYCLES(SE), .B32_CYCLES(B32),
        .B64_CYCLES(B64), .CE_CYCLES(CE), .DP_CYCLES(DLY),
        .RES1_CYCLES(DLY), .RES2_CYCLES(DLY)) u_flash_seq (.clk, .rst_n,
        .cs_n, .sclk, .quad_io_in, .quad_io_out, .quad_io_oe, .protect_cfg,
        .write_latch_flag, .op_in_progress_flag, .deep_sleep_flag, .mem_wr,
        .erase_req);
    spi_host u_spi_host (.clk, .quad_io_out, .cs_n, .sclk, .quad_io_in);
    always #50 clk = ~clk;
    always @(posedge clk) begin
        if (erase_req.en) begin
            n_er <= n_er + 1;
            er_last <= erase_req;
        end
        if (mem_wr.en) begin
            n_mw <= n_mw + 1;
            mw_last <= mem_wr;
        end
        busy_cnt <= op_in_progress_flag ? busy_cnt + 1 : 0;
        if (!op_in_progress_flag && busy_cnt != 0) busy_len <= busy_cnt;
    end
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_tests++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic stop_test;
        if (n_errors == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    function automatic int dur(input logic [1:0] kd);
        return kd == 2'h0 ? SE : kd == 2'h1 ? B32 : kd == 2'h2 ? B64 : CE;
    endfunction
    task automatic wen;
        u_spi_host.send(flash_pkg::OPC_WR_ENABLE, 64'h0, 0, 1'b0);
    endtask
    initial begin
        #2_000_000;
        n_errors++;
        stop_test();
    end
    initial begin
        rows[0] = '{8'h20, 24'h123456, 24, 0, 6'h00, 0, 0, 0};
        rows[1] = '{8'h20, 24'h123456, 24, 1, 6'h00, 1, 0, 24'h123000};
        rows[2] = '{8'h52, 24'h12fabc, 24, 1, 6'h00, 1, 1, 24'h128000};
        rows[3] = '{8'hd8, 24'h12fabc, 24, 1, 6'h00, 1, 2, 24'h120000};
        rows[4] = '{8'h20, 24'h7f1234, 24, 1, 6'h02, 0, 0, 0};
        rows[5] = '{8'hd8, 24'h7e0000, 24, 1, 6'h02, 1, 2, 24'h7e0000};
        rows[6] = '{8'h60, 24'h0, 0, 1, 6'h00, 1, 3, 24'h0};
        rows[7] = '{8'hc7, 24'h0, 0, 1, 6'h0f, 1, 3, 24'h0};
        rows[8] = '{8'h60, 24'h0, 0, 1, 6'h02, 0, 0, 0};
        rows[9] = '{8'h20, 24'h123456, 23, 1, 6'h00, 0, 0, 0};
        rows[10] = '{8'hc7, 24'h0, 1, 1, 6'h00, 0, 0, 0};
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        foreach (rows[i]) begin
            protect_cfg <= rows[i].prot;
            if (rows[i].we) wen();
            chk("latch set", rows[i].we, write_latch_flag);
            k = n_er;
            u_spi_host.send(rows[i].opc, rows[i].addr, rows[i].nb, 1'b0);
            chk("busy", rows[i].en, op_in_progress_flag);
            repeat (CE + 20) @(posedge clk);
            chk("erase count", k + rows[i].en, n_er);
            if (rows[i].en) begin
                chk("erase kind", rows[i].kind, er_last.kind);
                chk("erase addr", rows[i].ea, er_last.addr);
                chk("busy length", dur(rows[i].kind), busy_len);
                chk("latch clear", 0, write_latch_flag);
            end
        end
        protect_cfg <= 6'h00;
        wen();
        k = n_mw;
        u_spi_host.send(flash_pkg::OPC_QUAD_PROG, 48'h1234feaabbcc, 12, 1);
        repeat (PP + 20) @(posedge clk);
        chk("prog bytes", k + 3, n_mw);
        chk("prog addr", 24'h1234ff, mw_last.addr);
        chk("prog data", 8'hbb, mw_last.data);
        chk("prog busy", PP, busy_len);
        wen();
        u_spi_host.send(flash_pkg::OPC_QUAD_PROG, 36'h1234feaab, 9, 1);
        protect_cfg <= 6'h02;
        wen();
        u_spi_host.send(flash_pkg::OPC_QUAD_PROG, 32'h7f000011, 8, 1);
        repeat (40) @(posedge clk);
        chk("bad prog", k + 3, n_mw);
        protect_cfg <= 6'h00;
        wen();
        u_spi_host.send(8'h60, 64'h0, 0, 1'b0);
        u_spi_host.send(flash_pkg::OPC_DEEP_SLEEP, 64'h0, 0, 1'b0);
        repeat (CE) @(posedge clk);
        chk("sleep while busy", 0, deep_sleep_flag);
        u_spi_host.send(flash_pkg::OPC_DEEP_SLEEP, 64'h0, 0, 1'b0);
        chk("sleep entry", 0, deep_sleep_flag);
        repeat (DLY) @(posedge clk);
        chk("asleep", 1, deep_sleep_flag);
        wen();
        chk("latch asleep", 0, write_latch_flag);
        // 24 dummy bits, then 16 clocks that read the id back twice
        u_spi_host.send(flash_pkg::OPC_WAKE_ID, 64'h0, 40, 1'b0);
        chk("id oe", 0, quad_io_oe);
        chk("id", flash_pkg::DEV_ID_DEFAULT, u_spi_host.id_rd);
        chk("awake", 0, deep_sleep_flag);
        repeat (DLY + 10) @(posedge clk);
        wen();
        chk("latch awake", 1, write_latch_flag);
        u_spi_host.send(flash_pkg::OPC_DEEP_SLEEP, 64'h0, 0, 1'b0);
        repeat (DLY + 10) @(posedge clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        chk("reset standby", 0, deep_sleep_flag);
        stop_test();
    end
endmodule
